// >>> rtl/tmr_wave.sv
// compare waveform timer: 16-bit counter, period and three compare channels
// assumes an AXI4-Lite master and an asynchronous event level on count_event
module tmr_wave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic count_event,
	output logic [2:0] waveform_output,
	output logic [2:0] output_override,
	output logic pin_route
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// merge byte lanes of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge
	// merge byte lanes into a 16-bit register, upper lanes dropped on purpose
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = merge({16'h0000, old}, nw, strb);
		return r[15:0];
	endfunction : merge16
	// last prescaler count for each division
	function automatic logic [9:0] div_last(input logic [2:0] sel);
		case (sel)
			3'h0: div_last = 10'h000;
			3'h1: div_last = 10'h001;
			3'h2: div_last = 10'h003;
			3'h3: div_last = 10'h007;
			3'h4: div_last = 10'h00f;
			3'h5: div_last = 10'h03f;
			3'h6: div_last = 10'h0ff;
			default: div_last = 10'h3ff;
		endcase
	endfunction : div_last

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tmr_wave_pkg::control_t control; // software configuration
	logic [15:0] count; // counter value
	logic down; // present count direction
	logic [15:0] period; // active period
	logic [15:0] period_buffer; // pending period
	logic [15:0] compare_value [3]; // active compares
	logic [15:0] compare_buffer [3]; // pending compares
	logic [3:0] buffer_valid_flag; // period, then channels 0..2
	logic [2:0] match_flag; // sticky compare matches
	logic [2:0] match_pend; // equality seen on last tick
	logic [9:0] presc; // prescaler count
	logic [2:0] evt_sync; // event synchroniser
	logic evt_level; // filtered event level
	logic aw_got, w_got; // write halves held
	logic [7:0] waddr; // held write address
	logic [31:0] wdat; // held write data
	logic [3:0] wstb; // held byte enables
	logic next_aw_got, next_w_got, next_bvalid, next_rvalid;

	// ------------------------------------------------------------
	// bus write side
	// ------------------------------------------------------------
	wire do_write = aw_got && w_got && !bvalid; // both halves present
	always_comb
	begin
		next_aw_got = (aw_got && !do_write) || (awvalid && awready);
		next_w_got = (w_got && !do_write) || (wvalid && wready);
		next_bvalid = do_write || (bvalid && !bready);
	end
	// each half taken on its own; response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			bvalid <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			waddr <= 8'h00;
			wdat <= 32'h0000_0000;
			wstb <= 4'h0;
		end
		else
		begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			bvalid <= next_bvalid;
			// ready only when that half is free and no response waits
			awready <= !next_aw_got && !next_bvalid;
			wready <= !next_w_got && !next_bvalid;
			if (awvalid && awready)
				waddr <= awaddr;
			if (wvalid && wready)
			begin
				wdat <= wdata;
				wstb <= wstrb;
			end
		end
	end
	// unmapped offsets answer slave error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp <= tmr_wave_pkg::RESP_OKAY;
		else if (do_write)
			bresp <= (waddr > tmr_wave_pkg::OFS_CMPBUF0 + 8'h08 || waddr[1:0] != 2'b00) ?
				tmr_wave_pkg::RESP_SLVERR : tmr_wave_pkg::RESP_OKAY;
	end
	wire wr_ctl = do_write && waddr == tmr_wave_pkg::OFS_CONTROL;
	wire wr_cnt = do_write && waddr == tmr_wave_pkg::OFS_COUNT;
	wire wr_per = do_write && waddr == tmr_wave_pkg::OFS_PERIOD;
	wire wr_pbuf = do_write && waddr == tmr_wave_pkg::OFS_PERIOD_BUF;
	wire wr_stat = do_write && waddr == tmr_wave_pkg::OFS_STATUS;

	// ------------------------------------------------------------
	// bus read side
	// ------------------------------------------------------------
	always_comb
		next_rvalid = rvalid ? !rready : (arvalid && arready);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			arready <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= tmr_wave_pkg::RESP_OKAY;
		end
		else
		begin
			rvalid <= next_rvalid;
			arready <= !next_rvalid;
			if (arvalid && arready)
			begin
				rresp <= tmr_wave_pkg::RESP_OKAY;
				case (araddr)
					tmr_wave_pkg::OFS_CONTROL: rdata <= control;
					tmr_wave_pkg::OFS_STATUS: rdata <= {25'h0, buffer_valid_flag, match_flag};
					tmr_wave_pkg::OFS_COUNT: rdata <= {16'h0, count};
					tmr_wave_pkg::OFS_PERIOD: rdata <= {16'h0, period};
					tmr_wave_pkg::OFS_PERIOD_BUF: rdata <= {16'h0, period_buffer};
					8'h14: rdata <= {16'h0, compare_value[0]};
					8'h18: rdata <= {16'h0, compare_value[1]};
					8'h1c: rdata <= {16'h0, compare_value[2]};
					8'h20: rdata <= {16'h0, compare_buffer[0]};
					8'h24: rdata <= {16'h0, compare_buffer[1]};
					8'h28: rdata <= {16'h0, compare_buffer[2]};
					default:
					begin
						rdata <= 32'h0000_0000;
						rresp <= tmr_wave_pkg::RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	wire [31:0] ctl_merged = merge(control, wdat, wstb); // control word after a write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			control <= tmr_wave_pkg::CONTROL_RESET;
		else if (wr_ctl)
			control <= {18'h0, ctl_merged[13:0]};
	end

	// ------------------------------------------------------------
	// timer clock: prescaled bus clock or filtered event edges
	// ------------------------------------------------------------
	// a level counts once the second and third stages agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			evt_sync <= 3'h0;
			evt_level <= 1'b0;
		end
		else
		begin
			evt_sync <= {evt_sync[1:0], count_event};
			if (evt_sync[1] == evt_sync[2])
				evt_level <= evt_sync[2];
		end
	end
	wire evt_rise = evt_sync[1] == evt_sync[2] && evt_sync[2] && !evt_level;
	wire presc_tick = presc == div_last(control.prescale_select);
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !control.enable || presc_tick)
			presc <= 10'h000;
		else
			presc <= presc + 10'h001;
	end
	wire tick = control.enable && (control.event_count ? evt_rise : presc_tick);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	wire is_freq = control.waveform_mode_select == tmr_wave_pkg::MODE_FREQ;
	wire is_single = control.waveform_mode_select == tmr_wave_pkg::MODE_SINGLE;
	wire is_dual = control.waveform_mode_select == tmr_wave_pkg::MODE_DUAL;
	// compare 0 replaces the period in frequency mode
	wire [15:0] top = is_freq ? compare_value[0] : period;
	wire at_top = !down && count == top; // full-width compare, any top from one up
	// dual slope updates at top, the others where the count restarts
	wire upd_evt = tick && ((is_dual || !down) ? at_top : count == 16'h0000);
	wire upd = upd_evt && !control.lock_update_bit;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count <= 16'h0000;
			down <= 1'b0;
		end
		else
		begin
			// a count write beats counting
			if (wr_cnt)
				count <= merge16(count, wdat, wstb);
			else if (tick)
			begin
				if (is_dual)
				begin
					if (at_top)
					begin
						down <= 1'b1;
						count <= count - 16'h0001;
					end
					else if (down && count == 16'h0000)
					begin
						down <= 1'b0;
						count <= 16'h0001;
					end
					else
						count <= down ? count - 16'h0001 : count + 16'h0001;
				end
				else if (!down)
					// exact compare only: a count past top runs on and wraps
					count <= at_top ? 16'h0000 : count + 16'h0001;
				else
					count <= count == 16'h0000 ? top : count - 16'h0001;
			end
			// a control write sets the direction without stalling the count
			if (wr_ctl)
				down <= ctl_merged[7];
		end
	end

	// ------------------------------------------------------------
	// period and its buffer
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			period <= tmr_wave_pkg::PERIOD_RESET;
			period_buffer <= tmr_wave_pkg::PERIOD_RESET;
			buffer_valid_flag[0] <= 1'b0;
		end
		else
		begin
			if (wr_per)
				period <= merge16(period, wdat, wstb);
			else if (upd && buffer_valid_flag[0])
				period <= period_buffer;
			// a buffer write beats a same-cycle update
			if (wr_pbuf)
			begin
				period_buffer <= merge16(period_buffer, wdat, wstb);
				buffer_valid_flag[0] <= 1'b1;
			end
			else if (upd)
				buffer_valid_flag[0] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// compare channels
	// ------------------------------------------------------------
	for (genvar n = 0; n < tmr_wave_pkg::NUM_CH; n++)
	begin : g_ch
		wire [7:0] a_cmp = tmr_wave_pkg::OFS_CMP0 + 8'(n * 4);
		wire [7:0] a_buf = tmr_wave_pkg::OFS_CMPBUF0 + 8'(n * 4);
		wire wr_c = do_write && waddr == a_cmp;
		wire wr_b = do_write && waddr == a_buf;
		wire hit = count == compare_value[n];
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				compare_value[n] <= tmr_wave_pkg::CMP_RESET;
				compare_buffer[n] <= tmr_wave_pkg::CMP_RESET;
				buffer_valid_flag[n+1] <= 1'b0;
			end
			else
			begin
				if (wr_c)
					compare_value[n] <= merge16(compare_value[n], wdat, wstb);
				else if (upd && buffer_valid_flag[n+1])
					compare_value[n] <= compare_buffer[n];
				if (wr_b)
				begin
					compare_buffer[n] <= merge16(compare_buffer[n], wdat, wstb);
					buffer_valid_flag[n+1] <= 1'b1;
				end
				else if (upd)
					buffer_valid_flag[n+1] <= 1'b0;
			end
		end
		// flag follows the matching tick by two cycles; a new match beats a clear
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				match_pend[n] <= 1'b0;
				match_flag[n] <= 1'b0;
			end
			else
			begin
				match_pend[n] <= tick && hit;
				if (match_pend[n])
					match_flag[n] <= 1'b1;
				else if (wr_stat && wstb[0] && wdat[tmr_wave_pkg::STAT_MATCH_LSB + n])
					match_flag[n] <= 1'b0;
			end
		end
		// waveform: registered, so it moves one cycle after the tick
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				waveform_output[n] <= 1'b0;
			else if (!tick)
				waveform_output[n] <= waveform_output[n];
			else if (is_freq)
			begin
				// shift of channels 1 and 2 follows where the count stands
				if (hit)
					waveform_output[n] <= !waveform_output[n];
			end
			else if (is_single)
			begin
				if (compare_value[n] == 16'h0000)
					waveform_output[n] <= 1'b0;
				else if (hit)
					waveform_output[n] <= 1'b0;
				else if (count == 16'h0000)
					waveform_output[n] <= 1'b1;
			end
			else if (is_dual)
			begin
				if (compare_value[n] == 16'h0000)
					waveform_output[n] <= 1'b0;
				else if (compare_value[n] == period)
					waveform_output[n] <= 1'b1;
				else if (count == 16'h0000)
					waveform_output[n] <= 1'b1;
				else if (hit)
					waveform_output[n] <= down;
			end
			else
				waveform_output[n] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// pin override; direction and inversion stay with the port
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			output_override <= 3'h0;
			pin_route <= 1'b0;
		end
		else
		begin
			output_override <= (control.waveform_mode_select != tmr_wave_pkg::MODE_NORMAL) ?
				control.channel_output_enable : 3'h0;
			pin_route <= control.pin_route_selector;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_period_now;
		@(posedge aclk) disable iff (!aresetn)
		wr_per && wstb == 4'hf |=> period == $past(wdat[15:0]);
	endproperty
	a_period_now: assert property (p_period_now) else $error("period write not immediate");
	property p_wrap;
		@(posedge aclk) disable iff (!aresetn)
		tick && !is_dual && !down && count > top && !wr_cnt |=> count == $past(count) + 16'h0001;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count above period did not run on");
	property p_period_hold;
		@(posedge aclk) disable iff (!aresetn)
		!upd && !wr_per |=> $stable(period);
	endproperty
	a_period_hold: assert property (p_period_hold) else $error("period moved off update");
	property p_flag;
		@(posedge aclk) disable iff (!aresetn)
		tick && count == compare_value[0] |-> ##2 match_flag[0];
	endproperty
	a_flag: assert property (p_flag) else $error("match flag not set");
	property p_cmp_load;
		@(posedge aclk) disable iff (!aresetn)
		upd && buffer_valid_flag[1] && !g_ch[0].wr_c |=> compare_value[0] == $past(compare_buffer[0]);
	endproperty
	a_cmp_load: assert property (p_cmp_load) else $error("compare buffer not loaded");
	property p_override;
		@(posedge aclk) disable iff (!aresetn)
		output_override != 3'h0 |-> $past(control.waveform_mode_select) != tmr_wave_pkg::MODE_NORMAL;
	endproperty
	a_override: assert property (p_override) else $error("override without mode");
	property p_toggle;
		@(posedge aclk) disable iff (!aresetn)
		tick && is_freq && count == compare_value[0] |=> waveform_output[0] != $past(waveform_output[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("frequency output did not toggle");
	property p_ss_low;
		@(posedge aclk) disable iff (!aresetn)
		tick && is_single && compare_value[0] == 16'h0000 |=> !waveform_output[0];
	endproperty
	a_ss_low: assert property (p_ss_low) else $error("zero compare not low");
	property p_bv_clear;
		@(posedge aclk) disable iff (!aresetn)
		upd && !wr_pbuf |=> !buffer_valid_flag[0];
	endproperty
	a_bv_clear: assert property (p_bv_clear) else $error("valid flag kept after update");
	c_update: cover property (@(posedge aclk) disable iff (!aresetn) upd && buffer_valid_flag[0]);
	c_dual_turn: cover property (@(posedge aclk) disable iff (!aresetn) tick && is_dual && at_top);
	c_flag: cover property (@(posedge aclk) disable iff (!aresetn) match_pend[2]);
endmodule : tmr_wave

// >>> rtl/tmr_wave_pkg.sv
// constants, control layout and mode codes of the compare waveform timer
// assumes a single 10 MHz bus clock and a 32-bit AXI4-Lite register bus
package tmr_wave_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00; // control word
	localparam logic [7:0] OFS_STATUS = 8'h04; // match and buffer-valid flags
	localparam logic [7:0] OFS_COUNT = 8'h08; // counter value
	localparam logic [7:0] OFS_PERIOD = 8'h0c; // active period
	localparam logic [7:0] OFS_PERIOD_BUF = 8'h10; // period buffer
	localparam logic [7:0] OFS_CMP0 = 8'h14; // active compare, channel 0
	localparam logic [7:0] OFS_CMPBUF0 = 8'h20; // compare buffer, channel 0
	localparam logic [7:0] OFS_STEP = 8'h04; // spacing of channel registers
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int STAT_MATCH_LSB = 0; // match flags, write one to clear
	localparam int STAT_BV_LSB = 3; // buffer valid: period, cmp0..2
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam int NUM_CH = 3; // compare channels
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int CLK_PERIOD_NS = 100; // bus clock period
	// ------------------------------------------------------------
	// waveform modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_FREQ = 3'b001,
		MODE_SINGLE = 3'b011,
		MODE_DUAL = 3'b101
	} wave_mode_t;
	// control word, high bits first
	typedef struct packed {
		logic [17:0] unused; // reads as zero
		logic pin_route_selector; // bit 13: alternative pins
		logic event_count; // bit 12: count event edges
		logic [2:0] channel_output_enable; // bits 11:9
		logic lock_update_bit; // bit 8
		logic count_down; // bit 7
		wave_mode_t waveform_mode_select; // bits 6:4
		logic [2:0] prescale_select; // bits 3:1
		logic enable; // bit 0
	} control_t;
endpackage : tmr_wave_pkg

// >>> tb/tb_top.sv
// self-checking bench of the compare waveform timer, driven over AXI4-Lite
// assumes the package map and the register timing given by the designer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0; // clock and active-low reset
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf; // whole words only
	logic count_event = 1'b0; // event level, pulsed by the event counting test at the end
	logic awready, wready, bvalid, arready, rvalid, pin_route;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rv;
	logic [2:0] waveform_output, output_override;
	int fails = 0, compares = 0, seed = 61275;
	int hi[3], tg[3]; // high cycles and toggles per channel
	// ----------------------------------------
	// clock, design
	// ----------------------------------------
	always #(tmr_wave_pkg::CLK_PERIOD_NS / 2) aclk = ~aclk;
	tmr_wave tmr_wave_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.count_event(count_event), .waveform_output(waveform_output),
		.output_override(output_override), .pin_route(pin_route));
	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// a wait that runs out counts as a mismatch and closes the run
	task automatic timeout;
		fails++;
		$display("ERROR at %0t seen %h expected %h", $time, 32'h0, 32'h1);
		end_of_test();
	endtask : timeout
	// ----------------------------------------
	// bus master
	// ----------------------------------------
	// address and data offered together, each released at its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, wd;
		int n;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100 && !(ad && wd); n++)
		begin
			@(posedge aclk);
			if (!ad && awready)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		for (n = 0; n < 100 && !bvalid; n++)
			@(posedge aclk);
		if (n == 100 || !(ad && wd))
			timeout();
		resp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// arready counts only at an edge that already sees arvalid high
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!arready && n < 100);
		arvalid <= 1'b0;
		for (n = 0; n < 100 && !rvalid; n++)
			@(posedge aclk);
		if (n == 100)
			timeout();
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd
	// ----------------------------------------
	// reference model of the waveforms
	// ----------------------------------------
	// single slope: high for cmp counts of per+1, whole period above top
	function automatic int ss_hi(input int cmp, input int per);
		return (cmp > per) ? per + 1 : cmp;
	endfunction : ss_hi
	function automatic logic [31:0] ctl(input tmr_wave_pkg::wave_mode_t m, input logic [2:0] pre,
		input logic [2:0] en, input logic lock, input logic route);
		tmr_wave_pkg::control_t c;
		c = '0; // count_down stays clear: no down-counting single slope
		c.enable = 1'b1;
		c.prescale_select = pre;
		c.waveform_mode_select = m;
		c.lock_update_bit = lock;
		c.channel_output_enable = en;
		c.pin_route_selector = route;
		return c;
	endfunction : ctl
	function automatic logic [7:0] cmp_a(input int ch);
		return 8'(tmr_wave_pkg::OFS_CMP0 + tmr_wave_pkg::OFS_STEP * ch);
	endfunction : cmp_a
	// stop, clear count, load period and compares directly, then start
	task automatic setup(input logic [31:0] c, input int per, input int c0, input int c1,
		input int c2);
		wr(tmr_wave_pkg::OFS_CONTROL, 32'h0);
		wr(tmr_wave_pkg::OFS_COUNT, 32'h0);
		wr(tmr_wave_pkg::OFS_PERIOD, 32'(per));
		wr(cmp_a(0), 32'(c0));
		wr(cmp_a(1), 32'(c1));
		wr(cmp_a(2), 32'(c2));
		wr(tmr_wave_pkg::OFS_CONTROL, c);
		// registered outputs follow the new control two edges later
		repeat (2) @(posedge aclk);
	endtask : setup
	// let the outputs settle, then count over whole periods only
	task automatic run(input int settle, input int n);
		logic [2:0] prev;
		repeat (settle) @(posedge aclk);
		hi = '{0, 0, 0};
		tg = '{0, 0, 0};
		prev = waveform_output;
		repeat (n)
		begin
			@(posedge aclk);
			for (int i = 0; i < 3; i++)
			begin
				hi[i] += int'(waveform_output[i] === 1'b1);
				tg[i] += int'(waveform_output[i] !== prev[i]);
			end
			prev = waveform_output;
		end
	endtask : run
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int c[3];
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(tmr_wave_pkg::OFS_CONTROL);
		chk(rv, tmr_wave_pkg::CONTROL_RESET);
		rd(tmr_wave_pkg::OFS_PERIOD);
		chk(rv, 32'(tmr_wave_pkg::PERIOD_RESET));
		rd(cmp_a(1));
		chk(rv, 32'(tmr_wave_pkg::CMP_RESET));
		// unmapped and misaligned places are refused
		wr(8'h40, 32'h1234);
		chk(32'(resp), 32'(tmr_wave_pkg::RESP_SLVERR));
		wr(8'h02, 32'h1);
		chk(32'(resp), 32'(tmr_wave_pkg::RESP_SLVERR));
		rd(8'h40);
		chk({rv[29:0], resp}, {30'h0, tmr_wave_pkg::RESP_SLVERR});
		// single slope, divide by two: period 8 cycles
		setup(ctl(tmr_wave_pkg::MODE_SINGLE, 3'h1, 3'b111, 1'b0, 1'b1), 3, 0, 2, 5);
		chk(32'({output_override, pin_route}), 32'h0f); // bench stands in for the port
		run(16, 32);
		chk(32'(hi[0]), 32'(4 * 2 * ss_hi(0, 3)));
		chk(32'(hi[1]), 32'(4 * 2 * ss_hi(2, 3)));
		chk(32'(tg[1]), 32'h8);
		chk(32'(hi[2]), 32'(4 * 2 * ss_hi(5, 3)));
		// match flags: channel 2 above top never matches
		wr(tmr_wave_pkg::OFS_STATUS, 32'h7);
		repeat (20) @(posedge aclk);
		rd(tmr_wave_pkg::OFS_STATUS);
		chk(32'(rv[2:0]), 32'h3);
		// locked buffers wait, direct writes land at once
		setup(ctl(tmr_wave_pkg::MODE_SINGLE, 3'h0, 3'b111, 1'b1, 1'b0), 3, 0, 2, 5);
		wr(tmr_wave_pkg::OFS_PERIOD_BUF, 32'h7);
		wr(8'(tmr_wave_pkg::OFS_CMPBUF0 + tmr_wave_pkg::OFS_STEP), 32'h1);
		repeat (20) @(posedge aclk);
		rd(cmp_a(1));
		chk(rv, 32'h2);
		rd(tmr_wave_pkg::OFS_STATUS);
		chk(32'(rv[6:3]), 32'h5);
		wr(tmr_wave_pkg::OFS_PERIOD, 32'h6);
		rd(tmr_wave_pkg::OFS_PERIOD);
		chk(rv, 32'h6);
		wr(tmr_wave_pkg::OFS_CONTROL, ctl(tmr_wave_pkg::MODE_SINGLE, 3'h0, 3'b111, 1'b0, 1'b0));
		repeat (20) @(posedge aclk);
		rd(tmr_wave_pkg::OFS_PERIOD);
		chk(rv, 32'h7);
		rd(cmp_a(1));
		chk(rv, 32'h1);
		rd(tmr_wave_pkg::OFS_STATUS);
		chk(32'(rv[6:3]), 32'h0);
		run(16, 32);
		chk(32'(hi[1]), 32'(4 * ss_hi(1, 7)));
		// random duties at period 7, values up to one above top
		for (int k = 0; k < 3; k++)
		begin
			for (int i = 0; i < 3; i++)
			begin
				c[i] = {$random(seed)} % 9;
				wr(cmp_a(i), 32'(c[i]));
			end
			run(16, 32);
			for (int i = 0; i < 3; i++)
				chk(32'(hi[i]), 32'(4 * ss_hi(c[i], 7)));
		end
		// dual slope at period 3: six cycles a period, high 2*cmp
		setup(ctl(tmr_wave_pkg::MODE_DUAL, 3'h0, 3'b111, 1'b0, 1'b0), 3, 0, 3, 1);
		run(12, 24);
		chk(32'(hi[0]), 32'h0);
		chk(32'(hi[1]), 32'(24));
		chk(32'(hi[2]), 32'(4 * 2 * 1));
		chk(32'(tg[2]), 32'h8);
		// frequency mode, cmp0 3, divide by two: toggle every 8 cycles
		setup(ctl(tmr_wave_pkg::MODE_FREQ, 3'h1, 3'b011, 1'b0, 1'b0), 16'hffff, 3, 1, 0);
		run(32, 64);
		chk(32'(tg[0]), 32'h8);
		chk(32'(tg[1]), 32'h8);
		chk(32'(tg[2]), 32'h8); // compare zero still matches once a period
		chk(32'(output_override), 32'h3);
		// normal mode: no override, count runs past a lowered period
		setup(ctl(tmr_wave_pkg::MODE_NORMAL, 3'h0, 3'b111, 1'b0, 1'b0), 16'hffff, 1, 2, 3);
		chk(32'({output_override, waveform_output}), 32'h0);
		wr(tmr_wave_pkg::OFS_COUNT, 32'h0100);
		wr(tmr_wave_pkg::OFS_PERIOD, 32'h5);
		repeat (10) @(posedge aclk);
		rd(tmr_wave_pkg::OFS_COUNT);
		chk(32'(rv[15:0] > 16'h0100), 32'h1);
		// event counting: three filtered rising edges step the count by three
		setup(ctl(tmr_wave_pkg::MODE_NORMAL, 3'h0, 3'h0, 1'b0, 1'b0) | 32'h0000_1000, 16'hffff,
			1, 2, 3);
		repeat (3)
		begin
			count_event <= 1'b1;
			repeat (4) @(posedge aclk);
			count_event <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		rd(tmr_wave_pkg::OFS_COUNT);
		chk(rv, 32'h3);
		end_of_test();
	end
endmodule : tb_top
